// ==== lgwd_defines.vh ====
`ifndef LGWD_DEFINES_VH
`define LGWD_DEFINES_VH

// Reference timing capacitance and the least capacitance for linear scaling, in pF
`define LGWD_CAP_REF_PF 100000
`define LGWD_CAP_MIN_PF 10000
// Reference timings at 100 nF, in microseconds
`define LGWD_TRIG_US_REF 36000
`define LGWD_LOW_US_REF 18000
// Kick high pulse least length, in nanoseconds
`define LGWD_KICK_MIN_NS 500
// Internal reset reaction time, typical and maximum, in nanoseconds
`define LGWD_RR_TYP_NS 9000
`define LGWD_RR_MAX_NS 15000
// Capacitor discharge time at 100 nF, typical, in nanoseconds
`define LGWD_DISCH_NS_REF 1500
// Clock period in nanoseconds (40 MHz)
`define LGWD_CLK_NS 25
// Default activation thresholds, in microamps (pin open)
`define LGWD_ACT_UA_DEF 1100
`define LGWD_DEACT_UA_DEF 900
// Watchdog states
`define LGWD_ST_OFF 2'h0
`define LGWD_ST_WIN 2'h1
`define LGWD_ST_LOW 2'h2

`endif

// ==== lgwd_kick_filter.v ====
`timescale 1ns/100ps
`include "lgwd_defines.vh"

module lgwd_kick_filter #(
	parameter FILT_CYC = 20
) (
	input wire mclk,
	input wire rst_n,
	input wire kick_in,
	output reg kick_edge
);

// Kick must stay high FILT_CYC cycles before it counts as a rising edge
reg [7:0] high_cnt;
reg counted;

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		high_cnt <= 8'h00;
		// Armed only after a low, so a kick held through reset is no edge
		counted <= 1'b1; // R01
		kick_edge <= 1'b0;
	end else begin
		kick_edge <= 1'b0;
		if (!kick_in) begin
			high_cnt <= 8'h00;
			counted <= 1'b0;
		end else if (!counted) begin
			if (high_cnt >= FILT_CYC[7:0] - 8'h01) begin
				counted <= 1'b1;
				kick_edge <= 1'b1; // R01 R10
			end else begin
				high_cnt <= high_cnt + 8'h01;
			end
		end
	end
end

endmodule // lgwd_kick_filter

// ==== lgwd_watchdog.v ====
// How it works
// R01: Only a filtered rising edge on the kick input restarts the trigger window.
// R02: A window that ends with no edge pulls the watchdog fault output low.
// R03: Once low, the fault output stays low for the whole low time.
// R04: With no edges the period is window plus low time, a new window starting after low.
// R05: Window and low time scale with timing capacitance over 100 nF, valid from 10 nF.
// R06: Supervision is on above the activation threshold, off below the lower deactivation one.
// R07: With the adjust pin open the default threshold applies, a resistor selects another.
// R08: Fault and reset outputs are separate open-collector pins that may be wired, low dominant.
// R09: Reset output reacts to undervoltage within the internal reaction time plus discharge.
// R10: The controller holds each kick high for at least 0.5 us.
// R11: At 100 nF the low time is typically 18 ms, within 12 to 27 ms.
// R12: The model uses 36 ms window and 18 ms low time at 100 nF, scaled by capacitance.
// R13: While disabled the fault output is released and the window timer held at restart, once a low phase already running has run to its end.
`timescale 1ns/100ps
`include "lgwd_defines.vh"

module lgwd_watchdog #(
	parameter CAP_PF = `LGWD_CAP_REF_PF,
	parameter TRIG_CYC = ((`LGWD_TRIG_US_REF * 1000 / `LGWD_CLK_NS)
		/ (`LGWD_CAP_REF_PF / 1000)) * (CAP_PF / 1000),
	parameter LOW_CYC = ((`LGWD_LOW_US_REF * 1000 / `LGWD_CLK_NS)
		/ (`LGWD_CAP_REF_PF / 1000)) * (CAP_PF / 1000),
	parameter RR_CYC = (`LGWD_RR_TYP_NS + (`LGWD_DISCH_NS_REF / 100) * (CAP_PF / 1000))
		/ `LGWD_CLK_NS,
	parameter ACT_UA = `LGWD_ACT_UA_DEF,
	parameter DEACT_UA = `LGWD_DEACT_UA_DEF
) (
	input wire mclk,
	input wire rst_n,
	input wire watchdog_kick_input,
	input wire [15:0] load_current_ua,
	input wire adjust_resistor_fitted,
	input wire [15:0] adjusted_activation_ua,
	input wire [15:0] adjusted_deactivation_ua,
	input wire undervoltage,
	output wire watchdog_fault_output_o,
	output wire watchdog_fault_output_oe,
	output wire reset_output_n_o,
	output wire reset_output_n_oe,
	output wire wired_fault_n,
	output wire supervision_active,
	output wire cap_in_range
);

localparam KICK_CYC = (`LGWD_KICK_MIN_NS + `LGWD_CLK_NS - 1) / `LGWD_CLK_NS;
localparam [31:0] TRIG_LIM = (TRIG_CYC < 1) ? 32'h00000001 : TRIG_CYC;
localparam [31:0] LOW_LIM = (LOW_CYC < 1) ? 32'h00000001 : LOW_CYC;
// Reaction time includes the capacitor discharge at the fitted value
localparam [15:0] RR_LIM = (RR_CYC < 1) ? 16'h0001 : RR_CYC[15:0];

// Scaling only holds from 10 nF upward; below that timing is merely indicative
assign cap_in_range = (CAP_PF >= `LGWD_CAP_MIN_PF); // R05

wire kick_edge;
reg [1:0] state;
reg [1:0] next_state;
reg [31:0] timer;
reg [31:0] next_timer;
reg active;
reg fault_low;
reg [15:0] rr_cnt;
reg reset_low;
reg [15:0] act_th;
reg [15:0] deact_th;
reg next_active;
reg next_fault_low;
reg [15:0] next_rr_cnt;
reg next_reset_low;
wire trig_done;
wire low_done;
wire rr_done;

// Short kick pulses are dropped before the window logic sees them
lgwd_kick_filter #(
	.FILT_CYC(KICK_CYC)
) u_kick_filter (
	.mclk(mclk),
	.rst_n(rst_n),
	.kick_in(watchdog_kick_input),
	.kick_edge(kick_edge)
);

// Open adjust pin falls back to the built-in pair
always @* begin
	if (adjust_resistor_fitted) begin
		act_th = adjusted_activation_ua; // R07
		deact_th = adjusted_deactivation_ua; // R07
	end else begin
		act_th = ACT_UA[15:0]; // R07
		deact_th = DEACT_UA[15:0]; // R07
	end
end

// Hysteresis keeps a sleeping controller from being woken by its own silence
// Equal to a threshold keeps the present state
always @* begin
	next_active = active;
	if (!active && load_current_ua > act_th) begin
		next_active = 1'b1; // R06
	end else if (active && load_current_ua < deact_th) begin
		next_active = 1'b0; // R06
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		active <= 1'b0;
	end else begin
		active <= next_active; // R06
	end
end

assign supervision_active = active;

// Limits are at least one, so the minus one never wraps
assign trig_done = (timer >= TRIG_LIM - 32'h00000001); // R02 R12
assign low_done = (timer >= LOW_LIM - 32'h00000001); // R03 R11
assign rr_done = (rr_cnt >= RR_LIM - 16'h0001); // R09

// Window and low phase share one timer; it restarts on every change of state
always @* begin
	next_state = state;
	next_timer = timer;
	case (state)
	`LGWD_ST_OFF: begin
		next_timer = 32'h00000000; // R13
		if (active) begin
			next_state = `LGWD_ST_WIN;
		end
	end
	`LGWD_ST_WIN: begin
		if (!active) begin
			next_state = `LGWD_ST_OFF; // R13
			next_timer = 32'h00000000;
		end else if (kick_edge) begin
			next_timer = 32'h00000000; // R01
		end else if (trig_done) begin
			next_state = `LGWD_ST_LOW; // R02 R12
			next_timer = 32'h00000000;
		end else begin
			next_timer = timer + 32'h00000001;
		end
	end
	`LGWD_ST_LOW: begin
		// Kicks are ignored here; the low phase always runs to the end
		if (low_done) begin
			next_state = active ? `LGWD_ST_WIN : `LGWD_ST_OFF; // R03 R04 R11
			next_timer = 32'h00000000;
		end else begin
			next_timer = timer + 32'h00000001; // R03
		end
	end
	default: begin
		next_state = `LGWD_ST_OFF;
		next_timer = 32'h00000000;
	end
	endcase
end

// Fault pin is registered so the open collector never glitches
always @* begin
	next_fault_low = 1'b0;
	if (next_state == `LGWD_ST_LOW) begin
		next_fault_low = 1'b1; // R02 R03
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		state <= `LGWD_ST_OFF;
	end else begin
		state <= next_state;
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		timer <= 32'h00000000;
	end else begin
		timer <= next_timer;
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		fault_low <= 1'b0;
	end else begin
		fault_low <= next_fault_low; // R02
	end
end

// Reset path: undervoltage must persist the reaction time before the pin drops
// Counter restarts whenever undervoltage drops out
always @* begin
	next_rr_cnt = rr_cnt;
	next_reset_low = reset_low;
	if (!undervoltage) begin
		next_rr_cnt = 16'h0000;
		next_reset_low = 1'b0;
	end else if (rr_done) begin
		next_reset_low = 1'b1; // R09
	end else begin
		next_rr_cnt = rr_cnt + 16'h0001; // R09
	end
end

always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		rr_cnt <= 16'h0000;
		reset_low <= 1'b0;
	end else begin
		rr_cnt <= next_rr_cnt;
		reset_low <= next_reset_low;
	end
end

// Open collector: drive low only, pull-up is external
assign watchdog_fault_output_o = 1'b0; // R08
assign watchdog_fault_output_oe = fault_low; // R08
assign reset_output_n_o = 1'b0;
assign reset_output_n_oe = reset_low; // R08
assign wired_fault_n = ~(fault_low | reset_low); // R08

endmodule // lgwd_watchdog

// ==== lgwd_watchdog_checker.sv ====
`timescale 1ns/100ps
module lgwd_watchdog_checker #(
	parameter LOW_CYC = 50
) (
	input wire mclk,
	input wire rst_n,
	input wire [15:0] load_current_ua,
	input wire adjust_resistor_fitted,
	input wire [15:0] adjusted_activation_ua,
	input wire [15:0] adjusted_deactivation_ua,
	input wire undervoltage,
	input wire watchdog_fault_output_o,
	input wire watchdog_fault_output_oe,
	input wire reset_output_n_o,
	input wire reset_output_n_oe,
	input wire wired_fault_n,
	input wire supervision_active
);
	int low_n;
	wire [15:0] on_th = adjust_resistor_fitted ? adjusted_activation_ua : 16'h44c;
	wire [15:0] off_th = adjust_resistor_fitted ? adjusted_deactivation_ua : 16'h384;
	// Length of the current low phase
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			low_n <= 0;
		else
			low_n <= watchdog_fault_output_oe ? low_n + 1 : 0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	pins_low_a: assert property (!watchdog_fault_output_o && !reset_output_n_o)
		else $error("open collector data not low");
	wired_or_a: assert property (
		wired_fault_n == !(watchdog_fault_output_oe || reset_output_n_oe))
		else $error("wired level wrong");
	low_time_a: assert property ($fell(watchdog_fault_output_oe) |-> low_n == LOW_CYC)
		else $error("low time wrong");
	sleep_rel_a: assert property (
		!supervision_active && !watchdog_fault_output_oe |=> !watchdog_fault_output_oe)
		else $error("fault while disabled");
	act_on_a: assert property (load_current_ua > on_th |=> supervision_active)
		else $error("not activated");
	act_off_a: assert property (load_current_ua < off_th |=> !supervision_active)
		else $error("not deactivated");
	rr_cause_a: assert property (
		$rose(reset_output_n_oe) |-> undervoltage && $past(undervoltage))
		else $error("reset without undervoltage");
	rr_drop_a: assert property (!undervoltage |=> !reset_output_n_oe)
		else $error("reset held too long");
endmodule // lgwd_watchdog_checker
bind lgwd_watchdog lgwd_watchdog_checker #(.LOW_CYC(LOW_CYC)) lgwd_watchdog_checker_inst (.*);

// ==== lgwd_mcu_model.sv ====
`timescale 1ns/100ps
module lgwd_mcu_model (
	input wire mclk,
	input wire enable,
	output reg kick
);
	int n = 0;
	// 24 high cycles gives margin over the 20-cycle input filter
	always @(posedge mclk) begin
		n <= (enable && n < 64) ? n + 1 : 0;
		kick <= enable && n < 24;
	end
endmodule // lgwd_mcu_model

// ==== load_gated_edge_watchdog_tb.sv ====
`timescale 1ns/100ps
module load_gated_edge_watchdog_tb;
	logic mclk = 0, rst_n = 0, fit = 0, uv = 0, en = 0, kick, fo, ro, wf, act, cr;
	logic [15:0] load = 0;
	int miscompares = 0, n_compared = 0, c;
	initial forever #12.5 mclk = ~mclk;
	lgwd_mcu_model lgwd_mcu_model_inst (.mclk(mclk), .enable(en), .kick(kick));
	lgwd_watchdog #(.TRIG_CYC(100), .LOW_CYC(50), .RR_CYC(10)) lgwd_watchdog_inst (
		.mclk(mclk), .rst_n(rst_n), .watchdog_kick_input(kick), .load_current_ua(load),
		.adjust_resistor_fitted(fit), .adjusted_activation_ua(16'h1388),
		.adjusted_deactivation_ua(16'h0fa0), .undervoltage(uv), .watchdog_fault_output_o(),
		.watchdog_fault_output_oe(fo), .reset_output_n_o(), .reset_output_n_oe(ro),
		.wired_fault_n(wf), .supervision_active(act), .cap_in_range(cr));
	task check(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic wait_for(ref logic s, input logic v);
		c = 0;
		while (s !== v) begin
			@(posedge mclk);
			#1 c++;
			if (c > 400) begin
				miscompares++;
				tally_and_finish;
			end
		end
	endtask
	task load_to(logic [15:0] v, logic exp);
		@(posedge mclk) load <= v;
		repeat (3) @(posedge mclk);
		#1 check("active", exp, act);
	endtask
	task kicked;
		@(posedge mclk) en <= 1;
		load_to(16'h07d0, 1);
		c = 0;
		repeat (400) begin
			@(posedge mclk);
			#1 c += (fo !== 1'b0);
		end
		check("fault while kicked", 0, c);
	endtask
	task missing;
		@(posedge mclk) en <= 0;
		wait_for(fo, 1);
		check("wired low", 0, wf);
		@(posedge mclk) en <= 1;
		wait_for(fo, 0);
		// One edge went to raising the kick enable
		check("low time", 50, c + 1);
		@(posedge mclk) en <= 0;
		wait_for(fo, 1);
		check("window after low", 100, c + 1);
	endtask
	task hysteresis;
		wait_for(fo, 0);
		load_to(16'h03e8, 1);
		load_to(16'h0352, 0);
		load_to(16'h03e8, 0);
		c = 0;
		repeat (300) begin
			@(posedge mclk);
			#1 c += (fo !== 1'b0);
		end
		check("fault while disabled", 0, c);
		@(posedge mclk) fit <= 1;
		load_to(16'h1194, 0);
		load_to(16'h1450, 1);
	endtask
	task undervolt;
		@(posedge mclk) uv <= 1;
		wait_for(ro, 1);
		check("reaction in range", 1, c >= 9 && c <= 12);
		check("wired low", 0, wf);
		@(posedge mclk) uv <= 0;
		repeat (2) @(posedge mclk);
		#1 check("reset released", 0, ro);
	endtask
	task tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1;
		#1 check("cap range", 1, cr);
		kicked;
		missing;
		hysteresis;
		undervolt;
		tally_and_finish;
	end
endmodule // load_gated_edge_watchdog_tb
